// ### logic/fsr_flash_cmd.sv
// Serial flash command interpreter: suspend, resume, reset, unique ID, table read
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "fsr_defines.svh"
module fsr_flash_cmd
  import fsr_pkg::*;
#(
  parameter logic [127:0] UNIQUE_ID    = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, // Arbitrary
  parameter int           SUSP_LAT_CYC = `FSR_SUSP_LAT_CYC
)(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic [3:0]  sio_in,
  output logic      [3:0]  sio_out,
  output logic      [3:0]  sio_oe_out,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  output fsr_eng_cmd_s     eng_cmd_out
);

  if (SUSP_LAT_CYC < 1 || SUSP_LAT_CYC > 65535) begin : g_bad_lat
    $error("SUSP_LAT_CYC out of range");
  end

  localparam logic [15:0] LAT_LOAD = 16'(SUSP_LAT_CYC - 1);

  logic [2:0]   cs_sync_q;
  logic [2:0]   sclk_sync_q;
  logic [1:0]   si_sync_q;
  logic [7:0]   shift_q;
  logic [2:0]   bit_cnt_q;
  logic [2:0]   byte_cnt_q;
  logic [7:0]   opc_q;
  logic [23:0]  addr_q;
  logic [7:0]   out_sr_q;
  logic         out_en_q;
  logic         so_q;
  logic [4:0]   uid_idx_q;
  logic         arm_q;
  fsr_op_e      op_q;
  logic         latch_q;
  logic [15:0]  lat_cnt_q;
  logic [23:0]  erase_addr_q;
  logic [23:0]  erase_mask_q;
  fsr_kind_e    kind_q;
  logic [23:0]  op_addr_q;
  fsr_eng_cmd_s eng_q;
  logic [31:0]  rdata_q;

  logic         cs_high;
  logic         cs_fall;
  logic         cs_rise;
  logic         sclk_rise;
  logic         sclk_fall;
  logic [7:0]   sh_next;
  logic [7:0]   opc_now;
  logic [2:0]   lead;
  logic         byte_done;
  logic         opc_decode;
  logic         load_out;
  logic [7:0]   load_val;
  logic [7:0]   uid_byte;
  logic [7:0]   rom_byte;
  logic         one_byte;
  logic         exec_wr_en;
  logic         exec_pp;
  logic         exec_erase;
  logic         exec_susp;
  logic         exec_resume;
  logic         exec_arm;
  logic         exec_rst;
  logic         soft_rst;
  logic         eng_done;
  logic         pp_outside;
  logic [15:0]  status_w;

  // Pins come from the host's clock domain; the first stage is never looked at
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cs_sync_q   <= 3'b111;
      sclk_sync_q <= 3'b000;
      si_sync_q   <= 2'b00;
    end else if (ce_in) begin
      cs_sync_q   <= {cs_sync_q[1:0], cs_n_in};
      sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
      si_sync_q   <= {si_sync_q[0], sio_in[0]}; // RQ13
    end
  end

  always_comb begin
    cs_high   = cs_sync_q[1];
    cs_fall   = cs_sync_q[2] && !cs_sync_q[1];
    cs_rise   = !cs_sync_q[2] && cs_sync_q[1];
    sclk_rise = !cs_high && !sclk_sync_q[2] && sclk_sync_q[1];
    sclk_fall = !cs_high && sclk_sync_q[2] && !sclk_sync_q[1];
    sh_next   = {shift_q[6:0], si_sync_q[1]};
    byte_done = sclk_rise && (bit_cnt_q == 3'd7);
    opc_decode = byte_done && (byte_cnt_q == 3'd0); // RQ25
    opc_now   = (byte_cnt_q == 3'd0) ? sh_next : opc_q;
    case (opc_now)
      `FSR_OPC_RDSR, `FSR_OPC_RDSR2: lead = 3'd0;
      `FSR_OPC_UID_RD: lead = 3'd4; // RQ17
      `FSR_OPC_SFDP: lead = 3'd4; // RQ18
      default: lead = 3'd7;
    endcase
    load_out = byte_done && (lead != 3'd7) && (byte_cnt_q >= lead);
    uid_byte = uid_idx_q[4] ? `FSR_PT_FILL : UNIQUE_ID[{4'd15 - uid_idx_q[3:0], 3'b000} +: 8];
    case (opc_now)
      `FSR_OPC_RDSR:  load_val = status_w[7:0];
      `FSR_OPC_RDSR2: load_val = status_w[15:8];
      `FSR_OPC_UID_RD: load_val = uid_byte; // RQ17
      default:        load_val = (addr_q[23:8] == 16'h0) ? rom_byte : `FSR_PT_FILL;
    endcase
  end

  fsr_param_rom u_rom (
    .addr_in  (addr_q[7:0]),
    .data_out (rom_byte)
  );

  // Serial framing: bits in on rising clock, bits out on falling clock
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_q    <= 8'h00;
      bit_cnt_q  <= 3'd0;
      byte_cnt_q <= 3'd0;
      opc_q      <= `FSR_OPC_NONE;
      addr_q     <= 24'h0;
      out_sr_q   <= 8'hff;
      out_en_q   <= 1'b0;
      so_q       <= 1'b0;
      uid_idx_q  <= 5'd0;
    end else if (ce_in) begin
      if (cs_fall) begin
        bit_cnt_q  <= 3'd0;
        byte_cnt_q <= 3'd0;
        opc_q      <= `FSR_OPC_NONE;
        out_en_q   <= 1'b0;
        uid_idx_q  <= 5'd0;
      end else if (cs_high) begin
        // Select high ends any output at once
        out_en_q <= 1'b0; // RQ18
      end else begin
        if (sclk_rise) begin
          shift_q   <= sh_next;
          bit_cnt_q <= bit_cnt_q + 3'd1;
          if (byte_done) begin
            if (byte_cnt_q != 3'd7) begin
              byte_cnt_q <= byte_cnt_q + 3'd1;
            end
            if (opc_decode) begin
              opc_q <= sh_next; // RQ25
            end
            if (byte_cnt_q >= 3'd1 && byte_cnt_q <= 3'd3) begin
              addr_q <= {addr_q[15:0], sh_next}; // RQ18
            end
            if (load_out) begin
              out_sr_q <= load_val;
              out_en_q <= 1'b1;
              if (opc_now == `FSR_OPC_UID_RD && !uid_idx_q[4]) begin
                uid_idx_q <= uid_idx_q + 5'd1;
              end
              if (opc_now == `FSR_OPC_SFDP) begin
                addr_q <= addr_q + 24'd1;
              end
            end
          end
        end
        if (sclk_fall && out_en_q) begin
          so_q     <= out_sr_q[7];
          out_sr_q <= {out_sr_q[6:0], 1'b1};
        end
      end
    end
  end

  // Commands take effect when select rises after whole bytes only
  always_comb begin
    one_byte    = cs_rise && (bit_cnt_q == 3'd0) && (byte_cnt_q == 3'd1);
    exec_wr_en  = one_byte && (opc_q == `FSR_OPC_WR_EN);
    exec_susp   = one_byte && (opc_q == `FSR_OPC_SUSP);
    exec_resume = one_byte && (opc_q == `FSR_OPC_RESUME_A || opc_q == `FSR_OPC_RESUME_B);
    exec_arm    = one_byte && (opc_q == `FSR_OPC_RST_ARM);
    exec_rst    = one_byte && (opc_q == `FSR_OPC_RST);
    exec_pp     = cs_rise && (bit_cnt_q == 3'd0) && (byte_cnt_q >= 3'd5)
                  && (opc_q == `FSR_OPC_PP);
    exec_erase  = cs_rise && (bit_cnt_q == 3'd0) && (byte_cnt_q == 3'd4)
                  && (opc_q == `FSR_OPC_SE || opc_q == `FSR_OPC_BE32
                      || opc_q == `FSR_OPC_BE64);
    soft_rst    = exec_rst && arm_q; // RQ14
    eng_done    = reg_wr_in && (reg_addr_in == `FSR_REG_CTRL)
                  && reg_wdata_in[`FSR_CTRL_DONE_BIT];
    pp_outside  = ((addr_q ^ erase_addr_q) & erase_mask_q) != 24'h0; // RQ1
  end

  // Reset arming: anything but the arm or the reset command disarms, no-op included
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      arm_q <= 1'b0;
    end else if (ce_in) begin
      if (opc_decode && sh_next != `FSR_OPC_RST_ARM && sh_next != `FSR_OPC_RST) begin
        arm_q <= 1'b0; // RQ15 RQ12
      end else if (exec_arm) begin
        arm_q <= 1'b1;
      end else if (exec_rst) begin
        arm_q <= 1'b0;
      end
    end
  end

  // Operation state; the array engine reports completion through the done bit
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      op_q         <= OP_IDLE;
      latch_q      <= 1'b0;
      lat_cnt_q    <= 16'h0;
      erase_addr_q <= 24'h0;
      erase_mask_q <= `FSR_MASK_SECTOR;
      kind_q       <= KIND_PROG;
      op_addr_q    <= 24'h0;
      eng_q        <= '0;
    end else if (ce_in) begin
      eng_q.start   <= 1'b0;
      eng_q.suspend <= 1'b0;
      eng_q.resume  <= 1'b0;
      eng_q.abort   <= 1'b0;
      if (soft_rst) begin
        // Aborted data may be left corrupt in the array
        eng_q.abort <= (op_q != OP_IDLE); // RQ16
        op_q        <= OP_IDLE; // RQ14
        latch_q     <= 1'b0;
      end else if (eng_done && op_q == OP_ESUSP_PROG) begin
        op_q    <= OP_ESUSP; // RQ4
        latch_q <= 1'b0;
      end else if (eng_done && (op_q == OP_PROG || op_q == OP_ERASE
                                || op_q == OP_PSUSP_WAIT || op_q == OP_ESUSP_WAIT)) begin
        op_q    <= OP_IDLE; // RQ10
        latch_q <= 1'b0;
      end else if (op_q == OP_PSUSP_WAIT || op_q == OP_ESUSP_WAIT) begin
        if (lat_cnt_q == 16'h0) begin
          op_q    <= (op_q == OP_PSUSP_WAIT) ? OP_PSUSP : OP_ESUSP; // RQ23
          latch_q <= 1'b0; // RQ24
        end else begin
          lat_cnt_q <= lat_cnt_q - 16'h1;
        end
      end else if (exec_wr_en) begin
        if (op_q == OP_IDLE || op_q == OP_ESUSP) begin
          latch_q <= 1'b1; // RQ25
        end
      end else if (exec_pp && latch_q) begin
        // Programming under suspension only when an erase is the one held
        if (op_q == OP_IDLE || (op_q == OP_ESUSP && pp_outside)) begin // RQ1 RQ6
          op_q        <= (op_q == OP_IDLE) ? OP_PROG : OP_ESUSP_PROG;
          kind_q      <= KIND_PROG;
          op_addr_q   <= addr_q;
          eng_q.start <= 1'b1;
          eng_q.kind  <= KIND_PROG;
          eng_q.addr  <= addr_q;
        end
      end else if (exec_erase && latch_q && op_q == OP_IDLE) begin
        op_q         <= OP_ERASE;
        erase_addr_q <= addr_q;
        op_addr_q    <= addr_q;
        eng_q.start  <= 1'b1;
        eng_q.addr   <= addr_q;
        if (opc_q == `FSR_OPC_SE) begin
          kind_q       <= KIND_SECTOR;
          eng_q.kind   <= KIND_SECTOR;
          erase_mask_q <= `FSR_MASK_SECTOR;
        end else if (opc_q == `FSR_OPC_BE32) begin
          kind_q       <= KIND_BLK32;
          eng_q.kind   <= KIND_BLK32;
          erase_mask_q <= `FSR_MASK_BLK32;
        end else begin
          kind_q       <= KIND_BLK64;
          eng_q.kind   <= KIND_BLK64;
          erase_mask_q <= `FSR_MASK_BLK64;
        end
      end else if (exec_susp && (op_q == OP_PROG || op_q == OP_ERASE)) begin
        // A program started inside an erase suspension is not held here
        op_q          <= (op_q == OP_PROG) ? OP_PSUSP_WAIT : OP_ESUSP_WAIT; // RQ3
        lat_cnt_q     <= LAT_LOAD;
        eng_q.suspend <= 1'b1;
      end else if (exec_resume && (op_q == OP_PSUSP || op_q == OP_ESUSP)) begin
        op_q         <= (op_q == OP_PSUSP) ? OP_PROG : OP_ERASE; // RQ7
        latch_q      <= 1'b1; // RQ9
        eng_q.resume <= 1'b1;
      end
    end
  end

  always_comb begin
    status_w = 16'h0;
    status_w[`FSR_ST_BUSY] = (op_q == OP_PROG) || (op_q == OP_ERASE) || (op_q == OP_ESUSP_PROG)
                             || (op_q == OP_PSUSP_WAIT) || (op_q == OP_ESUSP_WAIT);
    status_w[`FSR_ST_LATCH] = latch_q;
    status_w[`FSR_ST_SUS_PROG]  = (op_q == OP_PSUSP); // RQ5
    status_w[`FSR_ST_SUS_ERASE] = (op_q == OP_ESUSP) || (op_q == OP_ESUSP_PROG); // RQ5
  end

  // Register port: read data stand in the cycle after the strobe only
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 32'h0;
    end else if (ce_in) begin
      rdata_q <= 32'h0;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `FSR_REG_STATUS: rdata_q <= {16'h0, status_w};
          `FSR_REG_OPINFO: rdata_q <= {6'h0, kind_q, op_addr_q};
          default:         rdata_q <= 32'h0;
        endcase
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign eng_cmd_out   = eng_q;
  // Only the serial output line is ever driven
  assign sio_out       = {2'b00, so_q, 1'b0};
  assign sio_oe_out    = {2'b00, out_en_q, 1'b0}; // RQ13

  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_flags_exclusive: assert property ( // RQ6
    !(status_w[`FSR_ST_SUS_PROG] && status_w[`FSR_ST_SUS_ERASE]))
    else $error("both suspended flags set");

  a_nested_prog_flags: assert property ( // RQ4
    (op_q == OP_ESUSP_PROG)
    |-> (status_w[`FSR_ST_BUSY] && latch_q && status_w[`FSR_ST_SUS_ERASE]))
    else $error("program in suspension lacks busy flags");

  a_nested_prog_done: assert property ( // RQ4
    (ce_in && eng_done && !soft_rst && op_q == OP_ESUSP_PROG)
    |=> (!status_w[`FSR_ST_BUSY] && !latch_q && op_q == OP_ESUSP))
    else $error("program completion did not clear flags");

  a_resume_flags: assert property ( // RQ9
    (ce_in && exec_resume && !soft_rst && !eng_done && (op_q == OP_PSUSP || op_q == OP_ESUSP))
    |=> (latch_q && status_w[`FSR_ST_BUSY] && !status_w[`FSR_ST_SUS_PROG]
         && !status_w[`FSR_ST_SUS_ERASE]))
    else $error("resume did not update flags");

  a_suspend_latency: assert property ( // RQ24
    (ce_in && op_q == OP_ESUSP_WAIT && lat_cnt_q == 16'h0 && !soft_rst && !eng_done)
    |=> (status_w[`FSR_ST_SUS_ERASE] && !latch_q && !status_w[`FSR_ST_BUSY]))
    else $error("erase suspend not reached after latency");

  a_no_nested_susp: assert property ( // RQ3
    (ce_in && exec_susp && op_q == OP_ESUSP_PROG && !eng_done) |=> (op_q == OP_ESUSP_PROG))
    else $error("program inside erase suspension was suspended");

  a_pp_region_guard: assert property ( // RQ1
    (ce_in && exec_pp && latch_q && op_q == OP_ESUSP && !soft_rst && !eng_done)
    |=> ((op_q == OP_ESUSP_PROG) == $past(pp_outside)))
    else $error("program inside suspended region handled wrongly");

  a_arm_cancel: assert property ( // RQ15
    (ce_in && opc_decode && sh_next != `FSR_OPC_RST && sh_next != `FSR_OPC_RST_ARM) |=> !arm_q)
    else $error("reset arm survived another command");

  a_soft_reset: assert property ( // RQ14
    (ce_in && soft_rst) |=> (op_q == OP_IDLE && status_w == 16'h0 && !arm_q))
    else $error("software reset left volatile state");

  a_table_pads: assert property ( // RQ22
    (addr_q[23:8] == 16'h0 && (addr_q[7:0] == 8'h07 || addr_q[7:0] == 8'h0f
                               || addr_q[7:0] == `FSR_PT_HDR_LAST)) |-> (rom_byte == 8'hff))
    else $error("table pad byte not fill");

endmodule : fsr_flash_cmd

// ### inc/fsr_defines.svh
// Constants of the flash suspend, reset, unique ID and parameter table command logic
// Notes on behaviour
// RQ1: While erase is suspended, accept page program outside the suspended sector or block.
// RQ2: Host sends write enable before every page program, also during erase suspension.
// RQ3: Program started during erase suspension cannot be suspended; finishes before erase resume.
// RQ4: During that program both latch and in-progress flags read 1, clear on completion.
// RQ5: Program-suspended flag is status bit 15, erase-suspended flag is status bit 10.
// RQ6: Program during suspension only while an erase, never a program, is suspended.
// RQ7: Resume restarts whichever of program, sector erase or block erase is suspended.
// RQ8: Host checks no page program is running before resuming a suspended erase.
// RQ9: On resume, latch and in-progress flags go to 1, suspended flag goes to 0.
// RQ10: Resumed operation continues until done or until a new suspend arrives.
// RQ11: Host waits the resume gap before sending another suspend.
// RQ12: No-op only cancels a pending reset arm and touches nothing else.
// RQ13: Upper data lines are ignored during no-op and software reset.
// RQ14: Reset right after reset arm returns to standby with power-on volatile state.
// RQ15: Any other command after reset arm cancels the arming.
// RQ16: Software reset during program or erase aborts that operation.
// RQ17: Unique ID read: opcode, four dummy bytes, then the 128-bit factory value.
// RQ18: Table read: opcode, three address bytes, one dummy, then bytes until select rises.
// RQ19: Table bytes 0-6 hold signature 53 46 44 50, revisions 00 01, header count 01.
// RQ20: First header: ID 00, revision 1.0, length 09 words, pointer 000030.
// RQ21: Second header at 10: vendor code, revision 1.0, length 03 words, pointer 000060.
// RQ22: Header bytes 07, 0F and 17 always read FF.
// RQ23: Suspended flags set to 1 when their operation is suspended.
// RQ24: After suspend latency, latch flag clears and the suspended flag sets.
// RQ25: First byte after select falls is the opcode; disallowed commands are ignored.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

`define FSR_OPC_NONE      8'hff
`define FSR_OPC_WR_EN     8'h06
`define FSR_OPC_PP        8'h02
`define FSR_OPC_SE        8'h20
`define FSR_OPC_BE32      8'h52
`define FSR_OPC_BE64      8'hd8
`define FSR_OPC_SUSP      8'h75
`define FSR_OPC_RESUME_A  8'h7a
`define FSR_OPC_RESUME_B  8'h30
`define FSR_OPC_NO_OP     8'h00
`define FSR_OPC_RST_ARM   8'h66
`define FSR_OPC_RST       8'h99
`define FSR_OPC_UID_RD    8'h4b
`define FSR_OPC_SFDP      8'h5a
`define FSR_OPC_RDSR      8'h05
`define FSR_OPC_RDSR2     8'h35

`define FSR_ST_BUSY       0
`define FSR_ST_LATCH      1
`define FSR_ST_SUS_ERASE  10
`define FSR_ST_SUS_PROG   15

`define FSR_MASK_SECTOR   24'hfff000
`define FSR_MASK_BLK32    24'hff8000
`define FSR_MASK_BLK64    24'hff0000

`define FSR_REG_STATUS    4'h0
`define FSR_REG_CTRL      4'h4
`define FSR_REG_OPINFO    4'h8
`define FSR_CTRL_DONE_BIT 0

`define FSR_CLK_NS        50
`define FSR_SUSP_LAT_NS   30000
`define FSR_SUSP_LAT_CYC  ((`FSR_SUSP_LAT_NS + `FSR_CLK_NS - 1) / `FSR_CLK_NS)

`define FSR_PT_HDR_LAST   8'h17
`define FSR_PT_FILL       8'hff

`endif

// ### inc/fsr_pkg.sv
// Types shared by the flash command logic
package fsr_pkg;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_PROG,
    OP_ERASE,
    OP_PSUSP_WAIT,
    OP_ESUSP_WAIT,
    OP_PSUSP,
    OP_ESUSP,
    OP_ESUSP_PROG
  } fsr_op_e;

  typedef enum logic [1:0] {
    KIND_PROG,
    KIND_SECTOR,
    KIND_BLK32,
    KIND_BLK64
  } fsr_kind_e;

  typedef struct packed {
    logic        start;
    logic        suspend;
    logic        resume;
    logic        abort;
    fsr_kind_e   kind;
    logic [23:0] addr;
  } fsr_eng_cmd_s;

endpackage : fsr_pkg

// ### logic/fsr_param_rom.sv
// Parameter table header bytes
`timescale 1ns/1ps
`include "fsr_defines.svh"
module fsr_param_rom
  import fsr_pkg::*;
#(
  parameter logic [7:0] VENDOR_CODE = 8'h3c  // Arbitrary value
)(
  input  wire logic [7:0] addr_in,
  output logic      [7:0] data_out
);

  always_comb begin
    case (addr_in)
      8'h00: data_out = 8'h53; // RQ19
      8'h01: data_out = 8'h46;
      8'h02: data_out = 8'h44;
      8'h03: data_out = 8'h50;
      8'h04: data_out = 8'h00;
      8'h05: data_out = 8'h01;
      8'h06: data_out = 8'h01;
      8'h08: data_out = 8'h00; // RQ20
      8'h09: data_out = 8'h00;
      8'h0a: data_out = 8'h01;
      8'h0b: data_out = 8'h09;
      8'h0c: data_out = 8'h30;
      8'h0d: data_out = 8'h00;
      8'h0e: data_out = 8'h00;
      8'h10: data_out = VENDOR_CODE; // RQ21
      8'h11: data_out = 8'h00;
      8'h12: data_out = 8'h01;
      8'h13: data_out = 8'h03;
      8'h14: data_out = 8'h60;
      8'h15: data_out = 8'h00;
      8'h16: data_out = 8'h00;
      // Pad bytes and everything past the headers read as fill
      default: data_out = `FSR_PT_FILL; // RQ22
    endcase
  end

endmodule : fsr_param_rom

// ### tb/fsr_host_model.sv
// Host-side serial flash controller model: chip select, serial clock, data lines
`timescale 1ns/1ps
module fsr_host_model (
  input  wire logic       clk_in,
  input  wire logic       miso_in,
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic [3:0]      sio_out
);
  logic [2:0] noise_q;
  logic       mosi_q;

  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_q   = 1'b0;
    noise_q  = 3'h5;
  end

  // Upper lines change every cycle so that nothing may lean on them
  always @(posedge clk_in) begin
    noise_q <= noise_q + 3'h3;
  end

  // Deselected, the serial input shows the inverse of the last bit sent
  assign sio_out = {noise_q, cs_n_out ? ~mosi_q : mosi_q};

  task automatic start();
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask : start

  // Mode 0 with 8 clk per bit; sclk stands low outside frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_q <= tx[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      // Sampled mid-high, well clear of the design's launch after the fall
      rx[i] = miso_in;
      repeat (2) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
  endtask : xfer

  task automatic stop();
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask : stop
endmodule : fsr_host_model

// ### tb/fsr_flash_cmd_tb.sv
// Self-checking bench for the flash command interpreter
`timescale 1ns/1ps
`include "fsr_defines.svh"
`define CHK(nm, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); \
  end \
end
module fsr_flash_cmd_tb;
  import fsr_pkg::*;
  localparam logic [127:0] UID = 128'h1122_3344_5566_7788_99aa_bbcc_ddee_f00f; // Arbitrary
  localparam logic [7:0]   OPC_WR_EN = 8'h06;
  localparam logic [7:0]   OPC_ARM   = 8'h66;
  localparam logic [7:0]   OPC_NO_OP = 8'h00;
  localparam logic [7:0]   OPC_UID   = 8'h4b;
  logic         clk, arst_n, ce, cs_n, sclk, miso, reg_wr, reg_rd;
  logic [3:0]   sio_in, sio_out, sio_oe, reg_addr;
  logic [31:0]  reg_wdata, reg_rdata;
  fsr_eng_cmd_s eng_cmd;
  logic [7:0]   tbl [$];
  logic [7:0]   uid [$];
  int           mismatches, n_compared, aborts, starts, susps, resumes;

  fsr_flash_cmd #(.UNIQUE_ID(UID), .SUSP_LAT_CYC(4)) dut (
    .clk_in(clk), .arst_n_in(arst_n), .ce_in(ce), .cs_n_in(cs_n), .sclk_in(sclk),
    .sio_in(sio_in), .sio_out(sio_out), .sio_oe_out(sio_oe), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .eng_cmd_out(eng_cmd));
  fsr_host_model host (.clk_in(clk), .miso_in(miso), .cs_n_out(cs_n), .sclk_out(sclk),
    .sio_out(sio_in));

  // Released line shows the inverse of its last bit, so an undriven bit never matches a repeat of that bit
  assign miso = sio_oe[1] ? sio_out[1] : ~sio_out[1];

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (eng_cmd.abort === 1'b1) aborts++;
    if (eng_cmd.start === 1'b1) starts++;
    if (eng_cmd.suspend === 1'b1) susps++;
    if (eng_cmd.resume === 1'b1) resumes++;
  end

  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(nm, exp, reg_rdata)
  endtask : rd_chk

  task automatic st(input logic [15:0] exp);
    rd_chk(4'h0, {16'h0, exp}, "status");
  endtask : st

  task automatic wr_done();
    @(posedge clk);
    reg_addr  <= 4'h4;
    reg_wdata <= 32'h1;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr_done

  task automatic cmd(input logic [7:0] opc, input int nadr = 0, input logic [23:0] a = 24'h0);
    logic [7:0] rx;
    host.start();
    host.xfer(opc, rx);
    for (int i = nadr - 1; i >= 0; i--) host.xfer(a[8*i +: 8], rx);
    if (opc === `FSR_OPC_PP) host.xfer(8'ha5, rx);
    host.stop();
  endtask : cmd

  // Zero bytes stand for address and dummy bytes after the opcode
  task automatic rd_stream(input logic [7:0] opc, input int npre, input logic [7:0] exp [$],
                           input string nm);
    logic [7:0] rx;
    host.start();
    host.xfer(opc, rx);
    repeat (npre) host.xfer(8'h00, rx);
    foreach (exp[i]) begin
      host.xfer(8'h00, rx);
      `CHK(nm, exp[i], rx)
    end
    host.stop();
  endtask : rd_stream

  task automatic susp_wait();
    cmd(`FSR_OPC_SUSP);
    repeat (8) @(posedge clk);
  endtask : susp_wait

  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    st(16'h0000);
    rd_chk(4'hc, 32'h0, "unmapped");
    rd_chk(4'h4, 32'h0, "ctrl");
    // Byte 10 is the vendor code, arbitrary in the rom
    tbl = {8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff, 8'h00, 8'h00, 8'h01,
           8'h09, 8'h30, 8'h00, 8'h00, 8'hff, 8'h3c, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00,
           8'h00, 8'hff, 8'hff};
    rd_stream(`FSR_OPC_SFDP, 4, tbl, "table");
    `CHK("output enable", 4'h0, sio_oe)
    for (int i = 15; i >= 0; i--) uid.push_back(UID[8*i +: 8]);
    uid.push_back(8'hff);
    rd_stream(OPC_UID, 4, uid, "unique id");
    cmd(OPC_WR_EN);
    cmd(`FSR_OPC_SE, 3, 24'h001000);
    st(16'h0003);
    rd_chk(4'h8, 32'h0100_1000, "opinfo");
    susp_wait();
    st(16'h0400);
    cmd(OPC_WR_EN);
    cmd(`FSR_OPC_PP, 3, 24'h001ff0);
    st(16'h0402);
    cmd(`FSR_OPC_PP, 3, 24'h002000);
    st(16'h0403);
    tbl = {8'h03, 8'h03};
    rd_stream(`FSR_OPC_RDSR, 0, tbl, "status lo");
    tbl = {8'h04};
    rd_stream(`FSR_OPC_RDSR2, 0, tbl, "status hi");
    rd_chk(4'h8, 32'h0000_2000, "opinfo");
    susp_wait();
    cmd(`FSR_OPC_RESUME_A);
    st(16'h0403);
    // A done strobe while the clock enable is low must be lost
    ce <= 1'b0;
    wr_done();
    ce <= 1'b1;
    st(16'h0403);
    wr_done();
    st(16'h0400);
    cmd(`FSR_OPC_RESUME_A);
    st(16'h0003);
    // Resume gap before the next suspend
    repeat (40) @(posedge clk);
    susp_wait();
    st(16'h0400);
    cmd(`FSR_OPC_RESUME_B);
    st(16'h0003);
    wr_done();
    st(16'h0000);
    cmd(OPC_WR_EN);
    cmd(`FSR_OPC_PP, 3, 24'h000100);
    susp_wait();
    st(16'h8000);
    cmd(OPC_WR_EN);
    cmd(`FSR_OPC_PP, 3, 24'h004000);
    st(16'h8000);
    cmd(`FSR_OPC_RESUME_B);
    st(16'h0003);
    cmd(OPC_ARM);
    cmd(OPC_NO_OP);
    cmd(`FSR_OPC_RST);
    st(16'h0003);
    `CHK("aborts", 0, aborts)
    cmd(OPC_ARM);
    cmd(`FSR_OPC_RST);
    st(16'h0000);
    `CHK("aborts", 1, aborts)
    cmd(OPC_WR_EN);
    cmd(`FSR_OPC_BE32, 3, 24'h010000);
    rd_chk(4'h8, 32'h0201_0000, "opinfo");
    susp_wait();
    cmd(OPC_WR_EN);
    cmd(`FSR_OPC_PP, 3, 24'h017f00);
    st(16'h0402);
    cmd(`FSR_OPC_PP, 3, 24'h018000);
    st(16'h0403);
    cmd(OPC_ARM);
    cmd(`FSR_OPC_RST);
    st(16'h0000);
    cmd(OPC_WR_EN);
    cmd(`FSR_OPC_BE64, 3, 24'h030000);
    rd_chk(4'h8, 32'h0303_0000, "opinfo");
    wr_done();
    st(16'h0000);
    `CHK("aborts", 2, aborts)
    `CHK("starts", 6, starts)
    `CHK("suspends", 4, susps)
    `CHK("resumes", 3, resumes)
    conclude();
  end

  // Tests take well under 1 ms; twice that means a hang
  initial begin
    #2000000;
    mismatches++;
    conclude();
  end
endmodule : fsr_flash_cmd_tb
